// *** pkg/ats_defs.vh ***
// Constants for the alarm and totalizer signal source block
`ifndef ATS_DEFS_VH
`define ATS_DEFS_VH
`define ATS_CLK_HZ 10000000
`define ATS_TICK_HZ 1000
`define ATS_ONE_SEC_MS 1000
`define ATS_COUNT_PULSE_MS 100
`define ATS_N_ANALOG_CH 7
`define ATS_N_FIXED_DIG 2
`define ATS_N_COMMS_DIG 24
`define ATS_N_ALARMS 48
`define ATS_N_GROUPS 12
`define ATS_GROUP_SEL_W 4
`define ATS_N_RT_ALARMS 4
`define ATS_N_TOTALIZERS 12
`define ATS_TYPE_W 3
`define ATS_ATYPE_PROCESS 3'h0
`define ATS_ATYPE_LATCH 3'h1
`define ATS_ATYPE_ANNUNC 3'h2
`define ATS_ITYPE_W 3
`define ATS_ITYPE_VFREE_DIG 3'h4
`define ATS_ITYPE_DC_DIG 3'h5
`define ATS_AXI_AW 8
`define ATS_REG_CTRL 8'h00
`define ATS_REG_COMMS_DIG 8'h04
`define ATS_REG_ALM_STATE_LO 8'h08
`define ATS_REG_ALM_STATE_HI 8'h0C
`define ATS_REG_ALM_ACK_LO 8'h10
`define ATS_REG_ALM_ACK_HI 8'h14
`define ATS_REG_GROUPS 8'h18
`define ATS_REG_TOT_RUN 8'h1C
`define ATS_REG_TOT_WRAP 8'h20
`define ATS_REG_TOT_STAGE 8'h24
`define ATS_REG_TOT_COUNT 8'h28
`define ATS_RESP_OKAY 2'h0
`define ATS_RESP_SLVERR 2'h2
`endif

// *** rtl/ats_pulse_timer.v ***
// Retriggerable pulse stretcher timed by a tick enable
`timescale 1ns/1ps
`default_nettype none
module ats_pulse_timer #(
	parameter integer TICKS = 1000,
	parameter integer CW = 10
) (
	input wire i_clk_sys,
	input wire i_rst,
	input wire i_tick,
	input wire i_trig,
	output wire o_active
);
	reg [CW-1:0] cnt_q;
	localparam [CW-1:0] LOAD = TICKS[CW-1:0];
	always @(posedge i_clk_sys) begin
		if (i_rst) begin
			cnt_q <= {CW{1'b0}};
		end else if (i_trig) begin
			cnt_q <= LOAD;
		end else if (i_tick && cnt_q != {CW{1'b0}}) begin
			cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
		end
	end
	assign o_active = (cnt_q != {CW{1'b0}});
endmodule // ats_pulse_timer
`default_nettype wire

// *** rtl/ats_signal_sources.v ***
// Alarm and totalizer signal sources with AXI4-Lite status access
// Operation
// - Analog channel digital state shown only for digital input types; fixed inputs if fitted.
// - Twenty-four digital states written over the serial link, not from pins.
// - Alarm state signals per alarm, valid only when that alarm is enabled.
// - Acknowledge tracking exists only for process, latch and annunciator alarms.
// - Twelve group outputs OR their alarms; valid only if any alarm enabled.
// - Any-alarm output set when any enabled alarm is active.
// - New-alarm event pulses when any alarm becomes active; e-mail trigger only.
// - Four real-time alarm outputs, each valid only when enabled.
// - Run state output follows counting while the totalizer is enabled.
// - Wrap output lasts one second per predetermined count with auto wrap on.
// - Wrap output latches until totalizer reset when auto wrap is off.
// - Intermediate count output lasts one second at the intermediate count.
// - Count pulse lasts 100 ms at each whole unit crossing.
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ats_defs.vh"
module ats_signal_sources #(
	parameter integer CLK_HZ = `ATS_CLK_HZ,
	parameter integer TICK_HZ = `ATS_TICK_HZ
) (
	input wire i_clk_sys,
	input wire i_rst,
	// Digital inputs, asynchronous pins
	input wire [`ATS_N_ANALOG_CH-1:0] i_analog_dig_pin,
	input wire [`ATS_N_ANALOG_CH*`ATS_ITYPE_W-1:0] i_analog_in_type,
	input wire [`ATS_N_ANALOG_CH-1:0] i_analog_mod_fitted,
	input wire [`ATS_N_FIXED_DIG-1:0] i_fixed_dig_pin,
	input wire i_dig_mod_fitted,
	output reg [`ATS_N_ANALOG_CH-1:0] o_analog_dig_state,
	output reg [`ATS_N_FIXED_DIG-1:0] o_fixed_dig_state,
	output wire [`ATS_N_COMMS_DIG-1:0] o_comms_dig_state,
	// Alarm engine
	input wire [`ATS_N_ALARMS-1:0] i_alarm_active,
	input wire [`ATS_N_ALARMS-1:0] i_alarm_enable,
	input wire [`ATS_N_ALARMS*`ATS_TYPE_W-1:0] i_alarm_type,
	input wire [`ATS_N_ALARMS*`ATS_GROUP_SEL_W-1:0] i_alarm_group,
	input wire [`ATS_N_ALARMS-1:0] i_alarm_ack,
	input wire [`ATS_N_RT_ALARMS-1:0] i_rt_alarm_active,
	input wire [`ATS_N_RT_ALARMS-1:0] i_rt_alarm_enable,
	output reg [`ATS_N_ALARMS-1:0] o_alarm_state,
	output reg [`ATS_N_ALARMS-1:0] o_alarm_ack_state,
	output reg [`ATS_N_ALARMS-1:0] o_alarm_ack_valid,
	output reg [`ATS_N_GROUPS-1:0] o_alarm_group,
	output reg o_alarm_group_valid,
	output reg o_any_alarm,
	output reg o_any_alarm_valid,
	output reg o_new_alarm,
	output reg [`ATS_N_RT_ALARMS-1:0] o_rt_alarm_state,
	// Totalizer engine
	input wire [`ATS_N_TOTALIZERS-1:0] i_tot_enable,
	input wire [`ATS_N_TOTALIZERS-1:0] i_tot_running,
	input wire [`ATS_N_TOTALIZERS-1:0] i_tot_auto_wrap,
	input wire [`ATS_N_TOTALIZERS-1:0] i_tot_reached_count,
	input wire [`ATS_N_TOTALIZERS-1:0] i_tot_reached_stage,
	input wire [`ATS_N_TOTALIZERS-1:0] i_tot_whole_unit,
	input wire [`ATS_N_TOTALIZERS-1:0] i_tot_reset,
	output reg [`ATS_N_TOTALIZERS-1:0] o_tot_run_state,
	output wire [`ATS_N_TOTALIZERS-1:0] o_tot_wrap,
	output wire [`ATS_N_TOTALIZERS-1:0] o_intermediate_count_output,
	output wire [`ATS_N_TOTALIZERS-1:0] o_tot_count_pulse,
	// AXI4-Lite slave
	input wire [`ATS_AXI_AW-1:0] i_s_axi_awaddr,
	input wire i_s_axi_awvalid,
	output wire o_s_axi_awready,
	input wire [31:0] i_s_axi_wdata,
	input wire [3:0] i_s_axi_wstrb,
	input wire i_s_axi_wvalid,
	output wire o_s_axi_wready,
	output reg [1:0] o_s_axi_bresp,
	output reg o_s_axi_bvalid,
	input wire i_s_axi_bready,
	input wire [`ATS_AXI_AW-1:0] i_s_axi_araddr,
	input wire i_s_axi_arvalid,
	output wire o_s_axi_arready,
	output reg [31:0] o_s_axi_rdata,
	output reg [1:0] o_s_axi_rresp,
	output reg o_s_axi_rvalid,
	input wire i_s_axi_rready
);
	localparam integer NA = `ATS_N_ALARMS;
	localparam integer NT = `ATS_N_TOTALIZERS;
	localparam integer TICK_DIV = CLK_HZ / TICK_HZ;
	localparam integer SEC_TICKS = (`ATS_ONE_SEC_MS * TICK_HZ + 999) / 1000;
	localparam integer CNT_TICKS = (`ATS_COUNT_PULSE_MS * TICK_HZ + 999) / 1000;
	localparam integer TIMER_W = 16;
	localparam integer DIV_W = 16;
	localparam [DIV_W-1:0] DIV_LAST = TICK_DIV[DIV_W-1:0] - 1'b1;

	// Pin synchronisers
	reg [`ATS_N_ANALOG_CH-1:0] adig_s1_q;
	reg [`ATS_N_ANALOG_CH-1:0] adig_s2_q;
	reg [`ATS_N_FIXED_DIG-1:0] fdig_s1_q;
	reg [`ATS_N_FIXED_DIG-1:0] fdig_s2_q;
	always @(posedge i_clk_sys) begin
		if (i_rst) begin
			adig_s1_q <= {`ATS_N_ANALOG_CH{1'b0}};
			adig_s2_q <= {`ATS_N_ANALOG_CH{1'b0}};
			fdig_s1_q <= {`ATS_N_FIXED_DIG{1'b0}};
			fdig_s2_q <= {`ATS_N_FIXED_DIG{1'b0}};
		end else begin
			adig_s1_q <= i_analog_dig_pin;
			adig_s2_q <= adig_s1_q;
			fdig_s1_q <= i_fixed_dig_pin;
			fdig_s2_q <= fdig_s1_q;
		end
	end

	// Millisecond tick divider
	reg [DIV_W-1:0] div_q;
	reg tick_q;
	always @(posedge i_clk_sys) begin
		if (i_rst) begin
			div_q <= {DIV_W{1'b0}};
			tick_q <= 1'b0;
		end else if (div_q == DIV_LAST) begin
			div_q <= {DIV_W{1'b0}};
			tick_q <= 1'b1;
		end else begin
			div_q <= div_q + {{(DIV_W-1){1'b0}}, 1'b1};
			tick_q <= 1'b0;
		end
	end

	// Software-written state
	reg [`ATS_N_COMMS_DIG-1:0] comms_dig_q;
	reg global_en_q;
	assign o_comms_dig_state = comms_dig_q;

	// Alarm combine logic
	reg [NA-1:0] alarm_prev_q;
	reg [NA-1:0] act_en;
	reg [NA-1:0] ack_ok;
	reg [`ATS_N_GROUPS-1:0] grp_d;
	reg [`ATS_N_ANALOG_CH-1:0] adig_d;
	reg [`ATS_TYPE_W-1:0] atype;
	reg [`ATS_ITYPE_W-1:0] itype;
	reg [`ATS_GROUP_SEL_W-1:0] gsel;
	integer k;
	always @* begin
		act_en = i_alarm_active & i_alarm_enable & {NA{global_en_q}};
		ack_ok = {NA{1'b0}};
		grp_d = {`ATS_N_GROUPS{1'b0}};
		adig_d = {`ATS_N_ANALOG_CH{1'b0}};
		atype = {`ATS_TYPE_W{1'b0}};
		itype = {`ATS_ITYPE_W{1'b0}};
		gsel = {`ATS_GROUP_SEL_W{1'b0}};
		for (k = 0; k < NA; k = k + 1) begin
			atype = i_alarm_type[k*`ATS_TYPE_W +: `ATS_TYPE_W];
			ack_ok[k] = i_alarm_enable[k] && (atype == `ATS_ATYPE_PROCESS ||
				atype == `ATS_ATYPE_LATCH || atype == `ATS_ATYPE_ANNUNC);
			gsel = i_alarm_group[k*`ATS_GROUP_SEL_W +: `ATS_GROUP_SEL_W];
			if (act_en[k] && gsel < `ATS_N_GROUPS) begin
				grp_d[gsel] = 1'b1;
			end
		end
		for (k = 0; k < `ATS_N_ANALOG_CH; k = k + 1) begin
			itype = i_analog_in_type[k*`ATS_ITYPE_W +: `ATS_ITYPE_W];
			adig_d[k] = adig_s2_q[k] && i_analog_mod_fitted[k] &&
				(itype == `ATS_ITYPE_VFREE_DIG || itype == `ATS_ITYPE_DC_DIG);
		end
	end

	always @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_analog_dig_state <= {`ATS_N_ANALOG_CH{1'b0}};
			o_fixed_dig_state <= {`ATS_N_FIXED_DIG{1'b0}};
			o_alarm_state <= {NA{1'b0}};
			o_alarm_ack_state <= {NA{1'b0}};
			o_alarm_ack_valid <= {NA{1'b0}};
			o_alarm_group <= {`ATS_N_GROUPS{1'b0}};
			o_alarm_group_valid <= 1'b0;
			o_any_alarm <= 1'b0;
			o_any_alarm_valid <= 1'b0;
			o_new_alarm <= 1'b0;
			o_rt_alarm_state <= {`ATS_N_RT_ALARMS{1'b0}};
			alarm_prev_q <= {NA{1'b0}};
			o_tot_run_state <= {NT{1'b0}};
		end else begin
			o_analog_dig_state <= adig_d;
			o_fixed_dig_state <= fdig_s2_q & {`ATS_N_FIXED_DIG{i_dig_mod_fitted}};
			o_alarm_state <= act_en;
			o_alarm_ack_state <= ~i_alarm_ack & act_en & ack_ok;
			o_alarm_ack_valid <= ack_ok;
			o_alarm_group <= grp_d;
			o_alarm_group_valid <= |i_alarm_enable;
			o_any_alarm <= |act_en;
			o_any_alarm_valid <= |i_alarm_enable;
			alarm_prev_q <= act_en;
			o_new_alarm <= |(act_en & ~alarm_prev_q);
			o_rt_alarm_state <= i_rt_alarm_active & i_rt_alarm_enable;
			o_tot_run_state <= i_tot_running & i_tot_enable;
		end
	end

	// Totalizer pulses
	reg [NT-1:0] count_prev_q;
	reg [NT-1:0] stage_prev_q;
	reg [NT-1:0] unit_prev_q;
	reg [NT-1:0] wrap_latch_q;
	wire [NT-1:0] count_evt = i_tot_reached_count & ~count_prev_q & i_tot_enable;
	wire [NT-1:0] stage_evt = i_tot_reached_stage & ~stage_prev_q & i_tot_enable;
	wire [NT-1:0] unit_evt = i_tot_whole_unit & ~unit_prev_q & i_tot_enable;
	wire [NT-1:0] wrap_pulse;
	wire [NT-1:0] stage_pulse;
	wire [NT-1:0] unit_pulse;
	always @(posedge i_clk_sys) begin
		if (i_rst) begin
			count_prev_q <= {NT{1'b0}};
			stage_prev_q <= {NT{1'b0}};
			unit_prev_q <= {NT{1'b0}};
			wrap_latch_q <= {NT{1'b0}};
		end else begin
			count_prev_q <= i_tot_reached_count;
			stage_prev_q <= i_tot_reached_stage;
			unit_prev_q <= i_tot_whole_unit;
			// Set wins over a reset in the same cycle
			wrap_latch_q <= (wrap_latch_q & ~i_tot_reset & i_tot_enable) |
				(count_evt & ~i_tot_auto_wrap);
		end
	end

	genvar g;
	generate
		for (g = 0; g < NT; g = g + 1) begin : g_tot
			ats_pulse_timer #(.TICKS(SEC_TICKS), .CW(TIMER_W)) u_wrap (
				.i_clk_sys(i_clk_sys),
				.i_rst(i_rst | i_tot_reset[g]),
				.i_tick(tick_q),
				.i_trig(count_evt[g] & i_tot_auto_wrap[g]),
				.o_active(wrap_pulse[g])
			);
			ats_pulse_timer #(.TICKS(SEC_TICKS), .CW(TIMER_W)) u_stage (
				.i_clk_sys(i_clk_sys),
				.i_rst(i_rst),
				.i_tick(tick_q),
				.i_trig(stage_evt[g]),
				.o_active(stage_pulse[g])
			);
			ats_pulse_timer #(.TICKS(CNT_TICKS), .CW(TIMER_W)) u_unit (
				.i_clk_sys(i_clk_sys),
				.i_rst(i_rst),
				.i_tick(tick_q),
				.i_trig(unit_evt[g]),
				.o_active(unit_pulse[g])
			);
		end
	endgenerate
	assign o_tot_wrap = (wrap_pulse | wrap_latch_q) & i_tot_enable;
	assign o_intermediate_count_output = stage_pulse & i_tot_enable;
	assign o_tot_count_pulse = unit_pulse & i_tot_enable;

	// AXI4-Lite write path
	reg aw_full_q;
	reg w_full_q;
	reg [`ATS_AXI_AW-1:0] awaddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	assign o_s_axi_awready = !aw_full_q && !o_s_axi_bvalid;
	assign o_s_axi_wready = !w_full_q && !o_s_axi_bvalid;
	wire wr_go = aw_full_q && w_full_q;
	integer b;
	always @(posedge i_clk_sys) begin
		if (i_rst) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			awaddr_q <= {`ATS_AXI_AW{1'b0}};
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			o_s_axi_bvalid <= 1'b0;
			o_s_axi_bresp <= `ATS_RESP_OKAY;
			comms_dig_q <= {`ATS_N_COMMS_DIG{1'b0}};
			global_en_q <= 1'b1;
		end else begin
			if (i_s_axi_awvalid && o_s_axi_awready) begin
				aw_full_q <= 1'b1;
				awaddr_q <= i_s_axi_awaddr;
			end
			if (i_s_axi_wvalid && o_s_axi_wready) begin
				w_full_q <= 1'b1;
				wdata_q <= i_s_axi_wdata;
				wstrb_q <= i_s_axi_wstrb;
			end
			if (wr_go) begin
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				o_s_axi_bvalid <= 1'b1;
				o_s_axi_bresp <= `ATS_RESP_OKAY;
				case ({awaddr_q[`ATS_AXI_AW-1:2], 2'b00})
					`ATS_REG_CTRL: begin
						if (wstrb_q[0]) begin
							global_en_q <= wdata_q[0];
						end
					end
					`ATS_REG_COMMS_DIG: begin
						for (b = 0; b < 3; b = b + 1) begin
							if (wstrb_q[b]) begin
								comms_dig_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
							end
						end
					end
					`ATS_REG_ALM_STATE_LO, `ATS_REG_ALM_STATE_HI, `ATS_REG_ALM_ACK_LO,
					`ATS_REG_ALM_ACK_HI, `ATS_REG_GROUPS, `ATS_REG_TOT_RUN,
					`ATS_REG_TOT_WRAP, `ATS_REG_TOT_STAGE, `ATS_REG_TOT_COUNT: begin
						o_s_axi_bresp <= `ATS_RESP_OKAY;
					end
					default: begin
						o_s_axi_bresp <= `ATS_RESP_SLVERR;
					end
				endcase
			end else if (o_s_axi_bvalid && i_s_axi_bready) begin
				o_s_axi_bvalid <= 1'b0;
			end
		end
	end

	// AXI4-Lite read path
	assign o_s_axi_arready = !o_s_axi_rvalid;
	always @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_s_axi_rvalid <= 1'b0;
			o_s_axi_rdata <= 32'h0000_0000;
			o_s_axi_rresp <= `ATS_RESP_OKAY;
		end else if (i_s_axi_arvalid && o_s_axi_arready) begin
			o_s_axi_rvalid <= 1'b1;
			o_s_axi_rresp <= `ATS_RESP_OKAY;
			case ({i_s_axi_araddr[`ATS_AXI_AW-1:2], 2'b00})
				`ATS_REG_CTRL: o_s_axi_rdata <= {31'h0000_0000, global_en_q};
				`ATS_REG_COMMS_DIG: o_s_axi_rdata <= {8'h00, comms_dig_q};
				`ATS_REG_ALM_STATE_LO: o_s_axi_rdata <= o_alarm_state[31:0];
				`ATS_REG_ALM_STATE_HI: o_s_axi_rdata <= {16'h0000, o_alarm_state[NA-1:32]};
				`ATS_REG_ALM_ACK_LO: o_s_axi_rdata <= o_alarm_ack_state[31:0];
				`ATS_REG_ALM_ACK_HI: o_s_axi_rdata <= {16'h0000, o_alarm_ack_state[NA-1:32]};
				`ATS_REG_GROUPS: o_s_axi_rdata <= {12'h000, o_rt_alarm_state, o_new_alarm,
					o_any_alarm_valid, o_any_alarm, o_alarm_group_valid, o_alarm_group};
				`ATS_REG_TOT_RUN: o_s_axi_rdata <= {20'h0_0000, o_tot_run_state};
				`ATS_REG_TOT_WRAP: o_s_axi_rdata <= {20'h0_0000, o_tot_wrap};
				`ATS_REG_TOT_STAGE: o_s_axi_rdata <= {20'h0_0000, o_intermediate_count_output};
				`ATS_REG_TOT_COUNT: o_s_axi_rdata <= {20'h0_0000, o_tot_count_pulse};
				default: begin
					o_s_axi_rdata <= 32'h0000_0000;
					o_s_axi_rresp <= `ATS_RESP_SLVERR;
				end
			endcase
		end else if (o_s_axi_rvalid && i_s_axi_rready) begin
			o_s_axi_rvalid <= 1'b0;
		end
	end
endmodule // ats_signal_sources
`default_nettype wire

// *** verification/ats_checker.sv ***
// Checker for the alarm and totalizer signal sources
`timescale 1ns/1ps
`default_nettype none
module ats_checker #(
	parameter integer CLK_HZ = 10000000,
	parameter integer TICK_HZ = 1000
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic [47:0] i_alarm_active,
	input wire logic [47:0] i_alarm_enable,
	input wire logic [143:0] i_alarm_type,
	input wire logic [47:0] i_alarm_ack,
	input wire logic [47:0] o_alarm_ack_state,
	input wire logic o_any_alarm,
	input wire logic o_new_alarm,
	input wire logic [11:0] i_tot_enable,
	input wire logic [11:0] i_tot_running,
	input wire logic [11:0] i_tot_auto_wrap,
	input wire logic [11:0] i_tot_reached_count,
	input wire logic [11:0] i_tot_reset,
	input wire logic [11:0] i_tot_whole_unit,
	input wire logic [11:0] o_tot_run_state,
	input wire logic [11:0] o_tot_wrap,
	input wire logic [11:0] o_tot_count_pulse
);
	localparam integer CP_MAX = 100 * (CLK_HZ / TICK_HZ) + 1;
	wire [47:0] trk;
	logic [47:0] act_q;
	logic rise_q;
	logic wu_q;
	integer cp_q;
	genvar g;
	for (g = 0; g < 48; g = g + 1) begin : g_trk
		assign trk[g] = i_alarm_type[g*3 +: 3] <= 3'h2;
	end
	// Width of the count pulse, restarted by a new event
	always @(posedge i_clk_sys) begin
		if (i_rst) begin
			act_q <= '0;
			rise_q <= 1'b0;
			wu_q <= 1'b0;
			cp_q <= 0;
		end else begin
			act_q <= i_alarm_active;
			rise_q <= |(i_alarm_active & ~act_q & i_alarm_enable);
			wu_q <= i_tot_whole_unit[0];
			cp_q <= (!o_tot_count_pulse[0] || (i_tot_whole_unit[0] && !wu_q)) ? 0 : cp_q + 1;
		end
	end
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	a_run_state: assert property (!$past(i_rst) |-> o_tot_run_state == $past(i_tot_running & i_tot_enable))
		else $error("run state wrong");
	a_any_alarm: assert property (!$past(i_rst) |-> o_any_alarm == $past(|(i_alarm_active & i_alarm_enable)))
		else $error("any alarm wrong");
	a_ack_untracked: assert property (!$past(i_rst) |-> (o_alarm_ack_state & ~$past(trk & i_alarm_active & ~i_alarm_ack)) == '0)
		else $error("ack flag set wrongly");
	a_new_alarm_event: assert property (!$past(i_rst) && !$past(i_rst, 2) && !$past(i_rst, 3)
		&& $past(i_alarm_enable) == $past(i_alarm_enable, 2) |-> o_new_alarm == rise_q)
		else $error("new alarm event wrong");
	a_wrap_set: assert property ($rose(i_tot_reached_count[0]) && i_tot_enable[0] && !i_tot_auto_wrap[0] |=> o_tot_wrap[0] || !i_tot_enable[0])
		else $error("wrap not set");
	a_wrap_hold: assert property (o_tot_wrap[0] && !i_tot_auto_wrap[0] && !i_tot_reset[0] |=> o_tot_wrap[0] || !i_tot_enable[0])
		else $error("latched wrap dropped");
	a_wrap_pulse: assert property ($rose(i_tot_reached_count[0]) && i_tot_enable[0] && i_tot_auto_wrap[0] |=> o_tot_wrap[0] [*8])
		else $error("wrap pulse short");
	a_count_start: assert property ($rose(i_tot_whole_unit[0]) && i_tot_enable[0] |=> o_tot_count_pulse[0])
		else $error("count pulse missing");
	a_count_width: assert property (cp_q <= CP_MAX)
		else $error("count pulse too long");
	c_new: cover property (o_new_alarm);
	c_latched: cover property (o_tot_wrap[0] && !i_tot_auto_wrap[0]);
	c_count_end: cover property ($fell(o_tot_count_pulse[0]));
endmodule // ats_checker
bind ats_signal_sources ats_checker #(.CLK_HZ(CLK_HZ), .TICK_HZ(TICK_HZ)) ats_checker_inst (
	.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_alarm_active(i_alarm_active),
	.i_alarm_enable(i_alarm_enable), .i_alarm_type(i_alarm_type), .i_alarm_ack(i_alarm_ack),
	.o_alarm_ack_state(o_alarm_ack_state), .o_any_alarm(o_any_alarm), .o_new_alarm(o_new_alarm),
	.i_tot_enable(i_tot_enable), .i_tot_running(i_tot_running), .i_tot_auto_wrap(i_tot_auto_wrap),
	.i_tot_reached_count(i_tot_reached_count), .i_tot_reset(i_tot_reset),
	.i_tot_whole_unit(i_tot_whole_unit), .o_tot_run_state(o_tot_run_state),
	.o_tot_wrap(o_tot_wrap), .o_tot_count_pulse(o_tot_count_pulse));
`default_nettype wire

// *** verification/ats_engine_model.sv ***
// Behavioural totalizer engine raising count, stage and whole-unit events
`timescale 1ns/1ps
`default_nettype none
module ats_engine_model #(
	parameter integer PRESET = 300,
	parameter integer STAGE = 150,
	parameter integer UNIT = 100
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic [11:0] i_step,
	input wire logic [7:0] i_amt,
	input wire logic [11:0] i_auto_wrap,
	input wire logic [11:0] i_tot_reset,
	output logic [11:0] o_reached_count = 12'h000,
	output logic [11:0] o_reached_stage = 12'h000,
	output logic [11:0] o_whole_unit = 12'h000
);
	integer cnt_q [12] = '{default: 0};
	always @(posedge i_clk_sys) begin
		for (int i = 0; i < 12; i++) begin
			integer n;
			n = cnt_q[i] + i_amt;
			o_whole_unit[i] <= !i_rst && i_step[i] && n / UNIT != cnt_q[i] / UNIT;
			o_reached_stage[i] <= !i_rst && i_step[i] && cnt_q[i] < STAGE && n >= STAGE;
			o_reached_count[i] <= !i_rst && i_step[i] && cnt_q[i] < PRESET && n >= PRESET;
			if (i_rst || i_tot_reset[i])
				cnt_q[i] <= 0;
			else if (i_step[i])
				cnt_q[i] <= (i_auto_wrap[i] && n >= PRESET) ? n - PRESET : n;
		end
	end
endmodule // ats_engine_model
`default_nettype wire

// *** verification/tb_top.sv ***
// Self-checking testbench for the alarm and totalizer signal sources
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk = 0, rst = 1, dfit = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
	logic [6:0] apin = 0, afit = 0;
	logic [20:0] atype = 0;
	logic [1:0] fpin = 0;
	logic [47:0] act = 0, aen = 0, ack = 0;
	logic [143:0] aty = 0;
	logic [191:0] agrp = 0;
	logic [3:0] rta = 0, rte = 0, wstrb = 0;
	logic [11:0] ten = 0, trun = 0, twrap = 0, treset = 0, step = 0;
	logic [7:0] amt = 0, awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0;
	wire [11:0] rcnt, rstg, wunit, o_gr, o_run, o_wrap, o_stage, o_cp;
	wire [6:0] o_ad;
	wire [1:0] o_fd, br, rr;
	wire [23:0] o_cd;
	wire [47:0] o_st, o_ak, o_akv;
	wire [3:0] o_rt;
	wire [31:0] rd;
	wire o_gv, o_any, o_anyv, o_new, awr, wr, arr, bv, rv;
	integer num_errors = 0, n_compared = 0, cyc = 0;
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	ats_signal_sources #(.CLK_HZ(32'h0000_03e8)) ats_signal_sources_inst (
		.i_clk_sys(clk), .i_rst(rst), .i_analog_dig_pin(apin), .i_analog_in_type(atype),
		.i_analog_mod_fitted(afit), .i_fixed_dig_pin(fpin), .i_dig_mod_fitted(dfit),
		.o_analog_dig_state(o_ad), .o_fixed_dig_state(o_fd), .o_comms_dig_state(o_cd),
		.i_alarm_active(act), .i_alarm_enable(aen), .i_alarm_type(aty), .i_alarm_group(agrp),
		.i_alarm_ack(ack), .i_rt_alarm_active(rta), .i_rt_alarm_enable(rte),
		.o_alarm_state(o_st), .o_alarm_ack_state(o_ak), .o_alarm_ack_valid(o_akv),
		.o_alarm_group(o_gr), .o_alarm_group_valid(o_gv), .o_any_alarm(o_any),
		.o_any_alarm_valid(o_anyv), .o_new_alarm(o_new), .o_rt_alarm_state(o_rt),
		.i_tot_enable(ten), .i_tot_running(trun), .i_tot_auto_wrap(twrap),
		.i_tot_reached_count(rcnt), .i_tot_reached_stage(rstg), .i_tot_whole_unit(wunit),
		.i_tot_reset(treset), .o_tot_run_state(o_run), .o_tot_wrap(o_wrap),
		.o_intermediate_count_output(o_stage), .o_tot_count_pulse(o_cp),
		.i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
		.i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wv), .o_s_axi_wready(wr),
		.o_s_axi_bresp(br), .o_s_axi_bvalid(bv), .i_s_axi_bready(bready),
		.i_s_axi_araddr(araddr), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
		.o_s_axi_rdata(rd), .o_s_axi_rresp(rr), .o_s_axi_rvalid(rv), .i_s_axi_rready(rready));
	ats_engine_model ats_engine_model_inst (.i_clk_sys(clk), .i_rst(rst), .i_step(step),
		.i_amt(amt), .i_auto_wrap(twrap), .i_tot_reset(treset), .o_reached_count(rcnt),
		.o_reached_stage(rstg), .o_whole_unit(wunit));
	always #50 clk = ~clk;
	task summarize;
		if (num_errors == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task check(input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
		logic pa, pw;
		@(posedge clk);
		bq.push_back(r);
		pa = 1;
		pw = 1;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awv <= 1;
		wv <= 1;
		bready <= 1;
		while (pa || pw) begin
			@(posedge clk);
			pa = pa && !awr;
			pw = pw && !wr;
			awv <= pa;
			wv <= pw;
		end
		while (!bv) @(posedge clk);
		bready <= 0;
	endtask
	task axi_rd(input logic [7:0] a, input logic [33:0] e);
		@(posedge clk);
		rq.push_back(e);
		araddr <= a;
		arv <= 1;
		rready <= 1;
		do @(posedge clk); while (!arr);
		arv <= 0;
		while (!rv) @(posedge clk);
		rready <= 0;
	endtask
	task stp(input logic [7:0] a);
		@(posedge clk);
		step <= 12'h001;
		amt <= a;
		@(posedge clk);
		step <= 12'h000;
	endtask
	function logic pick(input integer s);
		return s == 0 ? o_cp[0] : s == 1 ? o_wrap[0] : o_stage[0];
	endfunction
	task meas(input integer s, input integer lo, input integer hi);
		integer w;
		w = 0;
		repeat (10) if (!pick(s)) @(posedge clk);
		while (pick(s)) begin
			@(posedge clk);
			w++;
		end
		check(w >= lo && w <= hi, 1'b1);
	endtask
	function logic [47:0] trk();
		for (int i = 0; i < 48; i++) trk[i] = aty[i*3 +: 3] <= 3'h2;
	endfunction
	function logic [19:0] grpw();
		logic [11:0] g;
		g = 0;
		for (int i = 0; i < 48; i++)
			if (act[i] && aen[i] && agrp[i*4 +: 4] < 12) g[agrp[i*4 +: 4]] = 1;
		return {rta & rte, 1'b0, |aen, |(act & aen), |aen, g};
	endfunction
	// Register answers, oldest expectation first
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (bv && bready) check(br, bq.pop_front());
		if (rv && rready) check({rr, rd}, rq.pop_front());
		if (cyc == 20000) begin
			num_errors++;
			summarize();
		end
	end
	initial begin
		logic [31:0] d;
		logic [47:0] w;
		integer n;
		void'($urandom(32'h673a_33d9));
		repeat (2) @(posedge clk);
		rst <= 0;
		axi_rd(8'h00, 34'h1);
		for (int t = 0; t < 8; t++) begin
			@(posedge clk);
			atype <= {7{t[2:0]}};
			apin <= 7'h7f;
			afit <= 7'h55;
			fpin <= 2'h3;
			dfit <= t[0];
			repeat (4) @(posedge clk);
			check(o_ad, (t == 4 || t == 5) ? 7'h55 : 7'h00);
			check(o_fd, {2{t[0]}});
		end
		d = $urandom;
		axi_wr(8'h04, d, 4'hf, 2'h0);
		axi_rd(8'h04, {10'h0, d[23:0]});
		check(o_cd, d[23:0]);
		axi_wr(8'h04, ~d, 4'h2, 2'h0);
		axi_rd(8'h04, {10'h0, d[23:16], ~d[15:8], d[7:0]});
		axi_wr(8'h40, d, 4'hf, 2'h2);
		axi_rd(8'h40, {2'h2, 32'h0});
		axi_wr(8'h00, 32'h0000_0000, 4'h1, 2'h0);
		axi_rd(8'h00, 34'h0);
		axi_wr(8'h00, 32'h0000_0001, 4'h1, 2'h0);
		axi_rd(8'h00, 34'h1);
		axi_wr(8'h08, d, 4'hf, 2'h0);
		repeat (4) begin
			@(posedge clk);
			act <= 48'({$urandom, $urandom});
			aen <= 48'({$urandom, $urandom});
			ack <= 48'({$urandom, $urandom});
			aty <= 144'({$urandom, $urandom, $urandom, $urandom, $urandom});
			agrp <= 192'({$urandom, $urandom, $urandom, $urandom, $urandom, $urandom});
			{rta, rte} <= 8'($urandom);
			{trun, ten} <= 24'($urandom);
			repeat (4) @(posedge clk);
			w = act & aen & trk() & ~ack;
			check(o_st, act & aen);
			check(o_ak, w);
			check(o_akv, aen & trk());
			check({o_rt, o_new, o_anyv, o_any, o_gv, o_gr}, grpw());
			check(o_run, trun & ten);
			axi_rd(8'h0c, {18'h0, act[47:32] & aen[47:32]});
			axi_rd(8'h10, {2'h0, w[31:0]});
			axi_rd(8'h18, {14'h0, grpw()});
		end
		@(posedge clk);
		act <= 0;
		aen <= 48'hffff_ffff_ffff;
		repeat (4) @(posedge clk);
		act <= 48'h20;
		n = 0;
		repeat (6) begin
			@(posedge clk);
			n += o_new;
		end
		check(n, 1);
		ten <= 12'hfff;
		trun <= 12'hfff;
		stp(8'h64);
		meas(0, 100, 101);
		stp(8'h64);
		meas(2, 1000, 1001);
		stp(8'h64);
		repeat (50) @(posedge clk);
		stp(8'h64);
		meas(0, 95, 105);
		repeat (1200) @(posedge clk);
		check(o_wrap[0], 1'b1);
		treset <= 12'h001;
		@(posedge clk);
		treset <= 12'h000;
		repeat (3) @(posedge clk);
		check(o_wrap[0], 1'b0);
		twrap <= 12'hfff;
		repeat (3) stp(8'h64);
		meas(1, 1000, 1001);
		summarize();
	end
endmodule // tb_top
`default_nettype wire
